// ===== verilog/clock_bank_cfg.svh
// Constants for the clock bank gating and profile select block
`ifndef CLOCK_BANK_CFG_SVH
`define CLOCK_BANK_CFG_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS    20
`define LOSS_TIMEOUT_NS  1000
`define LOSS_TIMEOUT_CYC ((`LOSS_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_MIN_NS     100
`define RESET_MIN_CYC    ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_NS        2000
`define SETTLE_CYC       ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W            8

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define REG_CTRL         12'h000
`define REG_STATUS       12'h004
`define CTRL_THREE_BIT   0
`define CTRL_RSTPIN_BIT  1
`define CTRL_RESET       2'h3

// ----------------------------------------------------------------
// Divider increments, bank D in the top half-word, bank A lowest
// ----------------------------------------------------------------
`define ACC_W            16
`define INC_PROFILE1     64'h1000_0800_0400_0200
`define INC_PROFILE2     64'h2000_1000_0800_0400
`define INC_PROFILE3     64'h4000_2000_1000_0800

`endif

// ===== verilog/clock_bank_pkg.sv
// Types shared by the clock bank gating and profile select block
package clock_bank_pkg;

    typedef enum logic [2:0] {
        ST_POR        = 3'b000,
        ST_LOAD       = 3'b001,
        ST_SETTLE     = 3'b010,
        ST_RUN        = 3'b011,
        ST_RESET_HELD = 3'b100,
        ST_RESERVED   = 3'b101
    } plan_state_t;

    typedef logic [1:0] profile_t;

    typedef struct packed {
        logic       pin_alarm;
        logic [3:0] gates;
        logic       squelch;
        profile_t   profile;
        logic       lock_loss;
        logic       input_loss;
        logic       alarm;
    } status_t;

endpackage : clock_bank_pkg

// ===== verilog/bank_clock_gate.sv
// One output bank: fractional divider and glitch-free stop-low gate
`timescale 1ns/10ps
`default_nettype none
`include "clock_bank_cfg.svh"

module bank_clock_gate
    import clock_bank_pkg::*;
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Control
    input  wire logic               clear,
    input  wire logic [`ACC_W-1:0]  inc,
    input  wire logic               stop_req,
    // Outputs
    output logic      [1:0]         clocks_q,
    output logic                    gate_q
);

    logic [`ACC_W-1:0] acc_q;
    logic [`ACC_W-1:0] acc_d;
    logic              stop_q;
    logic              gate_d;

    // ------------------------------------------------------------
    // Fractional divider
    // ------------------------------------------------------------
    // Common clear keeps every bank phase-aligned after a load
    assign acc_d = clear ? '0 : acc_q + inc;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_d;
        end
    end

    // ------------------------------------------------------------
    // Gate
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stop_q <= 1'b1;
        end else begin
            stop_q <= stop_req;
        end
    end

    // Gate moves only while the clock is low, so no pulse is cut
    assign gate_d = (acc_d[`ACC_W-1] || clocks_q[0]) ? gate_q : !stop_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gate_q   <= 1'b0;
            clocks_q <= 2'b00;
        end else begin
            gate_q   <= gate_d;
            clocks_q <= {2{acc_d[`ACC_W-1] & gate_d}};
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_gate_quiet: assert property (@(posedge clk) disable iff (rst)
        !$stable(gate_q) |-> !clocks_q[0] && !$past(clocks_q[0]))
        else $error("bank gate moved while the clock was high");

    a_stopped_low: assert property (@(posedge clk) disable iff (rst)
        (stop_q && !gate_q) |=> clocks_q == 2'b00)
        else $error("stopped bank drove a high level");

    a_phase_clear: assert property (@(posedge clk) disable iff (rst)
        clear |=> acc_q == '0 && clocks_q == 2'b00)
        else $error("divider not cleared for alignment");

endmodule : bank_clock_gate
`default_nettype wire

// ===== verilog/clock_bank_gating_profile_select.sv
// Control logic of a four-bank clock generator: gating, profiles, alarm
// What this block does
// - Four banks of two clocks each, each bank with its own disable pin.
// - Master disable stops every bank regardless of bank pins.
// - A disabled bank drives both its clocks statically low.
// - Pin or lock-loss start and stop never produce a runt pulse; squelch clears the divider and can cut one.
// - Two-profile part: upper select 0 picks profile 1, 1 picks profile 2.
// - Three-profile part: 00 reserved, 01/10/11 pick profiles 1/2/3.
// - New select takes effect only on a long enough reset pin pulse.
// - All clocks squelched until the new profile is running.
// - Without a reset pin, select changes wait for power-on reset.
// - Alarm is the OR of input loss and lock loss.
// - On input loss alarm rises and outputs keep running.
// - On lock loss alarm rises and clock outputs are disabled.
// - Alarm clears when a suitable input returns; open-drain driver.
// - All outputs stay phase-aligned with one another.
// - Constant synthesis rate, one fractional divider per bank.
// - Disable pins: low enables, high disables.
// - Alarm reads 1 during input or lock loss, else 0.
`timescale 1ns/10ps
`default_nettype none
`include "clock_bank_cfg.svh"

module clock_bank_gating_profile_select
    import clock_bank_pkg::*;
(
    // Clock and power-on reset
    input  wire logic        clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Control pins
    input  wire logic        bank_a_disable_n,
    input  wire logic        bank_b_disable_n,
    input  wire logic        bank_c_disable_n,
    input  wire logic        bank_d_disable_n,
    input  wire logic        all_banks_disable_n,
    input  wire logic        plan_select_low,
    input  wire logic        plan_select_high,
    input  wire logic        device_reset,
    // Reference and synthesizer status
    input  wire logic        reference_clock_in,
    input  wire logic        lock_loss,
    // Open-drain alarm
    input  wire logic        input_loss_alarm_in,
    output logic             input_loss_alarm_out,
    output logic             input_loss_alarm_oe,
    // Bank clocks
    output logic      [1:0]  bank_a_clocks,
    output logic      [1:0]  bank_b_clocks,
    output logic      [1:0]  bank_c_clocks,
    output logic      [1:0]  bank_d_clocks
);

    // Literals cannot be part-selected, so the increment words live here
    localparam logic [63:0] INC_P1 = `INC_PROFILE1;
    localparam logic [63:0] INC_P2 = `INC_PROFILE2;
    localparam logic [63:0] INC_P3 = `INC_PROFILE3;

    plan_state_t          state_q;
    profile_t             profile_q;
    profile_t             decoded;
    logic [1:0]           ctrl_q;
    logic [`CNT_W-1:0]    settle_cnt_q;
    logic [`CNT_W-1:0]    rst_cnt_q;
    logic [`CNT_W-1:0]    loss_cnt_q;
    logic                 ref_prev_q;
    logic                 ref_edge;
    logic                 input_loss_q;
    logic                 lock_loss_q;
    logic                 alarm_q;
    logic                 squelch;
    logic                 rst_pin_on;
    logic [3:0]           bank_off;
    logic [3:0]           gates;
    logic [1:0]           bank_clk [4];
    status_t              status;

    assign rst_pin_on = ctrl_q[`CTRL_RSTPIN_BIT];
    assign squelch    = (state_q != ST_RUN);

    // ------------------------------------------------------------
    // Profile decode
    // ------------------------------------------------------------
    always_comb begin
        if (ctrl_q[`CTRL_THREE_BIT]) begin
            decoded = {plan_select_high, plan_select_low};
        end else begin
            decoded = plan_select_high ? 2'h2 : 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Profile state machine
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q      <= ST_POR;
            profile_q    <= 2'h0;
            settle_cnt_q <= '0;
        end else begin
            case (state_q)
                ST_POR: begin
                    state_q <= ST_LOAD;
                end
                ST_LOAD: begin
                    profile_q    <= decoded;
                    settle_cnt_q <= '0;
                    if (decoded == 2'h0) begin
                        state_q <= ST_RESERVED;
                    end else begin
                        state_q <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    settle_cnt_q <= settle_cnt_q + 1'b1;
                    if (settle_cnt_q == `CNT_W'(`SETTLE_CYC - 1)) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN, ST_RESERVED: begin
                    // Selects are only looked at in ST_LOAD
                    if (rst_pin_on && device_reset) begin
                        state_q <= ST_RESET_HELD;
                    end
                end
                ST_RESET_HELD: begin
                    if (!device_reset) begin
                        if (rst_cnt_q >= `CNT_W'(`RESET_MIN_CYC)) begin
                            state_q <= ST_LOAD;
                        end else if (profile_q == 2'h0) begin
                            state_q <= ST_RESERVED;
                        end else begin
                            state_q <= ST_RUN;
                        end
                    end
                end
                default: begin
                    state_q <= ST_POR;
                end
            endcase
        end
    end

    // Short pulses are ignored; width counted while the pin is high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rst_cnt_q <= '0;
        end else if (state_q != ST_RESET_HELD) begin
            rst_cnt_q <= '0;
        end else if (device_reset && rst_cnt_q != `CNT_W'(`RESET_MIN_CYC)) begin
            rst_cnt_q <= rst_cnt_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Input loss and alarm
    // ------------------------------------------------------------
    assign ref_edge = reference_clock_in ^ ref_prev_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_prev_q   <= 1'b0;
            loss_cnt_q   <= '0;
            input_loss_q <= 1'b1;
        end else begin
            ref_prev_q <= reference_clock_in;
            if (ref_edge) begin
                loss_cnt_q   <= '0;
                input_loss_q <= 1'b0;
            end else if (loss_cnt_q == `CNT_W'(`LOSS_TIMEOUT_CYC)) begin
                input_loss_q <= 1'b1;
            end else begin
                loss_cnt_q <= loss_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_loss_q          <= 1'b0;
            alarm_q              <= 1'b0;
            input_loss_alarm_out <= 1'b0;
            input_loss_alarm_oe  <= 1'b0;
        end else begin
            lock_loss_q          <= lock_loss;
            alarm_q              <= input_loss_q | lock_loss_q;
            // Driven only toward the active level, released otherwise
            input_loss_alarm_out <= input_loss_q | lock_loss_q;
            input_loss_alarm_oe  <= input_loss_q | lock_loss_q;
        end
    end

    // ------------------------------------------------------------
    // Banks
    // ------------------------------------------------------------
    // Pins read high as disable; input loss alone keeps clocks running
    assign bank_off = {bank_d_disable_n, bank_c_disable_n,
                       bank_b_disable_n, bank_a_disable_n};

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_bank
            logic [`ACC_W-1:0] inc;
            always_comb begin
                case (profile_q)
                    2'h1:    inc = INC_P1[i*`ACC_W +: `ACC_W];
                    2'h2:    inc = INC_P2[i*`ACC_W +: `ACC_W];
                    2'h3:    inc = INC_P3[i*`ACC_W +: `ACC_W];
                    default: inc = '0;
                endcase
            end
            bank_clock_gate u_bank (
                .clk      (clk),
                .rst      (rst),
                .clear    (squelch),
                .inc      (inc),
                .stop_req (bank_off[i] | all_banks_disable_n | squelch
                           | lock_loss_q),
                .clocks_q (bank_clk[i]),
                .gate_q   (gates[i])
            );
        end
    endgenerate

    assign bank_a_clocks = bank_clk[0];
    assign bank_b_clocks = bank_clk[1];
    assign bank_c_clocks = bank_clk[2];
    assign bank_d_clocks = bank_clk[3];

    // ------------------------------------------------------------
    // APB slave, one wait state
    // ------------------------------------------------------------
    always_comb begin
        status            = '0;
        status.alarm      = alarm_q;
        status.input_loss = input_loss_q;
        status.lock_loss  = lock_loss_q;
        status.profile    = profile_q;
        status.squelch    = squelch;
        status.gates      = gates;
        status.pin_alarm  = input_loss_alarm_in;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q  <= `CTRL_RESET;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (paddr == `REG_CTRL) begin
                if (pwrite && pstrb[0]) begin
                    ctrl_q <= pwdata[1:0];
                end
                prdata <= {30'h0, ctrl_q};
            end else if (paddr == `REG_STATUS) begin
                prdata <= {21'h0, status};
            end else begin
                pslverr <= 1'b1;
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_valid_load;
        state_q == ST_LOAD && decoded != 2'h0;
    endsequence

    property p_settle_squelch;
        @(posedge clk) disable iff (rst)
        s_valid_load |=> (state_q == ST_SETTLE && squelch) [*8];
    endproperty

    a_settle_squelch: assert property (p_settle_squelch)
        else $error("outputs left squelch too early");

    a_alarm_or: assert property (@(posedge clk) disable iff (rst)
        (input_loss_q || lock_loss_q) |=> alarm_q && input_loss_alarm_oe)
        else $error("alarm missed a loss condition");

    a_alarm_clear: assert property (@(posedge clk) disable iff (rst)
        !(input_loss_q || lock_loss_q) |=> !alarm_q && !input_loss_alarm_oe)
        else $error("alarm held without a loss condition");

    a_ref_return: assert property (@(posedge clk) disable iff (rst)
        ref_edge |=> !input_loss_q)
        else $error("input loss not cleared by reference activity");

    a_reserved_code: assert property (@(posedge clk) disable iff (rst)
        (state_q == ST_LOAD && decoded == 2'h0) |=> state_q == ST_RESERVED && squelch)
        else $error("reserved code did not hold squelch");

    a_two_profile: assert property (@(posedge clk) disable iff (rst)
        (state_q == ST_LOAD && !ctrl_q[`CTRL_THREE_BIT])
        |=> profile_q == ($past(plan_select_high) ? 2'h2 : 2'h1))
        else $error("two-profile decode wrong");

    a_select_ignored: assert property (@(posedge clk) disable iff (rst)
        (state_q != ST_LOAD) |=> $stable(profile_q))
        else $error("profile changed outside a load");

    a_short_reset: assert property (@(posedge clk) disable iff (rst)
        (state_q == ST_RESET_HELD && !device_reset
         && rst_cnt_q < `CNT_W'(`RESET_MIN_CYC)) |=> state_q != ST_LOAD)
        else $error("short reset pulse loaded a profile");

    a_master_off: assert property (@(posedge clk) disable iff (rst)
        all_banks_disable_n [*3] |-> (gates & ~$past(gates)) == 4'h0)
        else $error("bank started under master disable");

endmodule : clock_bank_gating_profile_select
`default_nettype wire

// ===== sim/board_ctrl_model.sv
// Board-side controller model: control pins, reference clock, alarm wire
`timescale 1ns/10ps
`default_nettype none

module board_ctrl_model (
    // Clock
    input  wire logic       clk,
    // Control pins toward the device
    output logic      [3:0] bank_off,
    output logic            all_off,
    output logic            sel_high,
    output logic            sel_low,
    output logic            dev_reset,
    output logic            ref_clk,
    // Open-drain alarm
    input  wire logic       alarm_out,
    input  wire logic       alarm_oe,
    output wire logic       alarm_wire
);
    logic ref_run;

    initial begin
        bank_off  = 4'h0;
        all_off   = 1'b0;
        sel_high  = 1'b1;
        sel_low   = 1'b1;
        dev_reset = 1'b0;
        ref_clk   = 1'b0;
        ref_run   = 1'b1;
    end

    // ----------------------------------------------------------------
    // Reference source
    // ----------------------------------------------------------------
    // Removed reference parks low, as a dead oscillator would
    always @(posedge clk) begin
        ref_clk <= ref_run ? ~ref_clk : 1'b0;
    end

    // Released wire rests at the inactive level
    assign alarm_wire = alarm_oe ? alarm_out : 1'b0;

    // ----------------------------------------------------------------
    // Pin sequences
    // ----------------------------------------------------------------
    // Reserved code only goes out when the bench asks for it
    task automatic set_select(input logic hi, input logic lo);
        @(posedge clk);
        sel_high <= hi;
        sel_low  <= lo;
    endtask : set_select

    // Selects stay put for the whole pulse and past its fall
    task automatic pulse_reset(input int cycles);
        @(posedge clk);
        dev_reset <= 1'b1;
        repeat (cycles) @(posedge clk);
        dev_reset <= 1'b0;
    endtask : pulse_reset

    // Bank and master pins move in one step, so one disable can replace another
    task automatic set_banks(input logic [3:0] banks, input logic all);
        @(posedge clk);
        bank_off <= banks;
        all_off  <= all;
    endtask : set_banks

    task automatic set_ref(input logic run);
        @(posedge clk);
        ref_run <= run;
    endtask : set_ref
endmodule : board_ctrl_model

`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the clock bank gating and profile select block
`timescale 1ns/10ps
`default_nettype none

module tb
    import clock_bank_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hf;
    logic        lock_loss = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, alarm_out, alarm_oe, alarm_wire, ref_clk;
    logic        all_off, sel_high, sel_low, dev_reset, last_err;
    logic [3:0]  bank_off;
    logic [1:0]  bank_a_clocks, bank_b_clocks, bank_c_clocks, bank_d_clocks;
    logic [31:0] rd;
    status_t     st;
    int          bad_count = 0;
    int          samples_checked = 0;

    always #10 clk = ~clk;

    board_ctrl_model u_board (
        .clk(clk), .bank_off(bank_off), .all_off(all_off), .sel_high(sel_high),
        .sel_low(sel_low), .dev_reset(dev_reset), .ref_clk(ref_clk),
        .alarm_out(alarm_out), .alarm_oe(alarm_oe), .alarm_wire(alarm_wire)
    );

    clock_bank_gating_profile_select u_dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .bank_a_disable_n(bank_off[0]), .bank_b_disable_n(bank_off[1]),
        .bank_c_disable_n(bank_off[2]), .bank_d_disable_n(bank_off[3]),
        .all_banks_disable_n(all_off), .plan_select_low(sel_low),
        .plan_select_high(sel_high), .device_reset(dev_reset),
        .reference_clock_in(ref_clk), .lock_loss(lock_loss),
        .input_loss_alarm_in(alarm_wire), .input_loss_alarm_out(alarm_out),
        .input_loss_alarm_oe(alarm_oe), .bank_a_clocks(bank_a_clocks),
        .bank_b_clocks(bank_b_clocks), .bank_c_clocks(bank_c_clocks),
        .bank_d_clocks(bank_d_clocks)
    );

    // ----------------------------------------------------------------
    // Checking and reporting
    // ----------------------------------------------------------------
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Records which banks showed any high level over the window
    task automatic watch(input int cycles, input logic [3:0] exp);
        logic [3:0] seen;
        seen = 4'h0;
        repeat (cycles) begin
            @(posedge clk);
            seen = seen | {|bank_d_clocks, |bank_c_clocks, |bank_b_clocks, |bank_a_clocks};
        end
        check("banks running", {28'h0, seen}, {28'h0, exp});
    endtask : watch

    task automatic wait_alarm(input logic exp, input int limit);
        int n;
        n = 0;
        while (alarm_wire !== exp) begin
            if (n == limit) begin
                bad_count++;
                final_report;
            end
            @(posedge clk);
            n++;
        end
        check("alarm pin", {31'h0, alarm_wire}, {31'h0, exp});
    endtask : wait_alarm

    // ----------------------------------------------------------------
    // APB master
    // ----------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata);
        int n;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= addr;
        pwdata <= wdata;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            final_report;
        end
        rdata    = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic get_status;
        apb(1'b0, 12'h004, 32'h0, rd);
        st = rd[10:0];
    endtask : get_status

    task automatic profile_is(input logic [1:0] exp);
        get_status;
        check("profile", {30'h0, st.profile}, {30'h0, exp});
    endtask : profile_is

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (110) @(posedge clk);
        apb(1'b0, 12'h000, 32'h0, rd);
        check("ctrl reset", rd, 32'h0000_0003);
        watch(40, 4'hf);
        wait_alarm(1'b0, 20);
        for (int i = 0; i < 4; i++) begin
            u_board.set_banks(4'h1 << i, 1'b0);
            repeat (20) @(posedge clk);
            watch(40, ~(4'h1 << i));
        end
        u_board.set_banks(4'h0, 1'b1);
        repeat (20) @(posedge clk);
        watch(40, 4'h0);
        u_board.set_banks(4'h0, 1'b0);
        watch(40, 4'hf);
        lock_loss <= 1'b1;
        wait_alarm(1'b1, 10);
        repeat (20) @(posedge clk);
        watch(40, 4'h0);
        lock_loss <= 1'b0;
        wait_alarm(1'b0, 10);
        u_board.set_ref(1'b0);
        wait_alarm(1'b1, 80);
        watch(40, 4'hf);
        u_board.set_ref(1'b1);
        wait_alarm(1'b0, 20);
        apb(1'b0, 12'h008, 32'h0, rd);
        check("unmapped err", {31'h0, last_err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        // A write with no lane strobes must leave the control word alone
        pstrb <= 4'h0;
        apb(1'b1, 12'h000, 32'h0000_0000, rd);
        pstrb <= 4'hf;
        apb(1'b0, 12'h000, 32'h0, rd);
        check("ctrl strobe", rd, 32'h0000_0003);
        apb(1'b1, 12'h004, 32'hffff_ffff, rd);
        profile_is(2'h3);
        for (int c = 1; c < 4; c++) begin
            u_board.set_select(c[1], c[0]);
            u_board.pulse_reset(6);
            watch(60, 4'h0);
            repeat (60) @(posedge clk);
            profile_is(c[1:0]);
            watch(140, 4'hf);
        end
        // Too short a pulse must leave the running plan alone
        u_board.set_select(1'b0, 1'b1);
        u_board.pulse_reset(3);
        watch(40, 4'hf);
        profile_is(2'h3);
        u_board.set_select(1'b0, 1'b0);
        u_board.pulse_reset(6);
        repeat (120) @(posedge clk);
        watch(140, 4'h0);
        get_status;
        check("squelch", {31'h0, st.squelch}, 32'h1);
        u_board.set_select(1'b1, 1'b1);
        u_board.pulse_reset(6);
        repeat (110) @(posedge clk);
        watch(40, 4'hf);
        apb(1'b1, 12'h000, 32'h0000_0002, rd);
        for (int h = 0; h < 2; h++) begin
            u_board.set_select(h[0], 1'b1);
            u_board.pulse_reset(6);
            repeat (120) @(posedge clk);
            profile_is(h[0] ? 2'h2 : 2'h1);
        end
        apb(1'b1, 12'h000, 32'h0000_0001, rd);
        u_board.set_select(1'b1, 1'b1);
        u_board.pulse_reset(6);
        repeat (120) @(posedge clk);
        profile_is(2'h2);
        u_board.set_select(1'b0, 1'b1);
        u_board.pulse_reset(6);
        watch(140, 4'hf);
        profile_is(2'h2);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (120) @(posedge clk);
        profile_is(2'h1);
        final_report;
    end
endmodule : tb

`default_nettype wire
